// >>> hw/remf_top.sv
// Early-receive monitor, multicast hash filter and AHB-Lite register slave
`timescale 1ns/1ps

// Block outline
// Bus side: zero-wait AHB-Lite slave, one word per register, low half used
// Network side: byte strobes and frame starts from the receive buffer writer
// Filter side: one destination address per strobe, verdict one cycle later
// Early receive event fires once per frame, on the byte that crosses the limit
// Limitation: byte count saturates, so very long frames simply stay flagged
// Limitation: threshold zero with enable set fires on the first written byte
// Unicast frames pass untouched; only group addresses consult the table
// Receive control, status and mask registers sit above the table words
// Trade-off: hash CRC is combinational, a long chain but no extra latency
// Sticky status bits clear by writing one; a same-cycle event wins
// Interrupt is registered from the next status, so it moves with the status bit
// Unmapped and misaligned accesses answer OKAY, writes dropped, reads zero
// Size of transfer is not checked; every access is taken as a whole word

// Operation
// - Early-receive monitoring acts only while the enable bit 7 is one.
// - Five-bit threshold in bits 4-0, in 64-byte units, resets to 0x1F.
// - Status sets once bytes written for current frame exceed the threshold.
// - Interrupt asserts on that same condition when its interrupt is enabled.
// - 64-bit hash table indexed by top six CRC bits of the 48-bit address.
// - Top two index bits pick the word, low four bits pick the bit.
// - Multicast frame whose selected table bit is one is accepted.
// - Multicast frame whose selected table bit is zero is dropped unless overridden.
// - Receive-all or receive-all-multicast accepts every multicast frame.
// - Four 16-bit read-write table words, each resetting to zero.
module remf_top
  import remf_pkg::*;
#(
  parameter int CNT_W = 12
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        rx_frame_start,
  input  wire logic        rx_byte_wr,
  input  wire logic        rx_da_valid,
  input  wire logic [47:0] rx_da,
  output logic             filt_valid,
  output logic             filt_accept,
  output logic             early_rx_flag,
  output logic             irq
);

  // All state of the block
  typedef struct packed {
    // Table words and control settings
    logic [MHASH_WORDS-1:0][MHASH_W-1:0] mhash;
    logic                                erx_en;
    logic [ERX_TH_W-1:0]                 erx_th;
    logic                                rx_all;
    logic                                rx_all_mc;

    // Interrupt bookkeeping
    logic [INT_W-1:0]                    int_sts;
    logic [INT_W-1:0]                    int_mask;

    // Per-frame early receive tracking
    logic [CNT_W-1:0]                    byte_cnt;
    logic                                early_flag;

    // Bus slave pipeline
    logic                                wr_pend;
    logic [5:0]                          wr_idx;
    logic [31:0]                         hrdata;
    logic                                hreadyout;
    logic                                hresp;

    // Filter verdict and interrupt line
    logic                                filt_valid;
    logic                                filt_accept;
    logic                                irq;
  } remf_state_t;

  remf_state_t state_reg;
  remf_state_t state_next;

  // CRC over the address, first octet in bits 7:0, each octet low bit first
  function automatic logic [31:0] remf_da_crc(input logic [DA_W-1:0] da);
    logic [31:0] c;
    logic        fb;
    fb = 1'b0;
    c  = CRC_INIT;
    // Shift register form; no final inversion, so the index is taken raw
    // Long chain of xors: fine at this clock, retime if the clock rises
    for (int i = 0; i < DA_W; i++) begin
      // Feedback is the outgoing top bit against the next address bit
      fb = c[31] ^ da[i];
      c  = {c[30:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction

  // Word index of an address, or all ones when outside the block
  function automatic logic [6:0] remf_decode(input logic [31:0] a);
    logic [6:0] r;
    r = 7'h7F;
    // Top bit of the result flags an address outside the block
    // Misaligned byte addresses are treated as outside as well
    if (a[31:8] == 24'h000000 && a[1:0] == 2'h0) begin
      r = {1'b0, a[7:2]};
    end
    return r;
  endfunction

  // Read value of a register from a given state copy
  function automatic logic [31:0] remf_read(input remf_state_t s, input logic [6:0] idx);
    logic [31:0] d;
    d = 32'h00000000;
    // Upper bits of every register read as zero
    // Holes in the map fall to the default and read zero
    case (idx)
      {1'b0, IDX_MHASH0}: begin
        d[MHASH_W-1:0] = s.mhash[0];
      end
      {1'b0, IDX_MHASH1}: begin
        d[MHASH_W-1:0] = s.mhash[1];
      end
      {1'b0, IDX_MHASH2}: begin
        d[MHASH_W-1:0] = s.mhash[2];
      end
      {1'b0, IDX_MHASH3}: begin
        d[MHASH_W-1:0] = s.mhash[3];
      end
      {1'b0, IDX_ERX_CTRL}: begin
        d[ERX_EN_BIT]                        = s.erx_en;
        d[ERX_TH_LSB +: ERX_TH_W]            = s.erx_th;
      end
      {1'b0, IDX_RX_CTRL}: begin
        d[RXC_ALL_BIT] = s.rx_all;
        d[RXC_MC_BIT]  = s.rx_all_mc;
      end
      {1'b0, IDX_INT_STS}: begin
        d[INT_W-1:0] = s.int_sts;
      end
      {1'b0, IDX_INT_MASK}: begin
        d[INT_W-1:0] = s.int_mask;
      end
      default: begin
        d = 32'h00000000;
      end
    endcase
    return d;
  endfunction

  // Filter lookup
  logic [31:0]           da_crc;
  logic [HASH_IDX_W-1:0] hash_idx;
  logic                  da_is_mcast;
  logic                  table_hit;

  // Early receive count
  logic [CNT_W-1:0]      cnt_inc;
  logic [CNT_W-1:0]      th_bytes;
  logic                  over_th;

  // Bus and status bookkeeping
  logic                  addr_phase;
  logic [6:0]            bus_idx;
  logic [INT_W-1:0]      int_set;
  logic [INT_W-1:0]      int_clr;

  // Hash lookup on the presented address
  always_comb begin
    da_crc      = remf_da_crc(rx_da);
    hash_idx    = da_crc[31:26];
    da_is_mcast = rx_da[0];
    table_hit   = state_reg.mhash[hash_idx[5:4]][hash_idx[3:0]];
  end

  // Per-frame count and the threshold in bytes
  // Count saturates instead of wrapping, so a long frame never looks short
  // A frame start with a byte in the same cycle counts that byte as one
  always_comb begin
    if (rx_frame_start) begin
      cnt_inc = rx_byte_wr ? CNT_W'(1) : CNT_W'(0);
    end else if (rx_byte_wr && state_reg.byte_cnt != {CNT_W{1'b1}}) begin
      cnt_inc = state_reg.byte_cnt + CNT_W'(1);
    end else begin
      cnt_inc = state_reg.byte_cnt;
    end
    th_bytes = CNT_W'({state_reg.erx_th, {ERX_UNIT_LG{1'b0}}});
    over_th  = cnt_inc > th_bytes;
  end

  // Next state of everything
  always_comb begin
    state_next = state_reg;
    int_set    = '0;
    int_clr    = '0;
    addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    bus_idx    = remf_decode(haddr);

    // Bus write lands in the data phase
    // The index was captured in the address phase, the data arrives now
    // Status takes write-one-to-clear; the others take the value as written
    if (state_reg.wr_pend) begin
      case (state_reg.wr_idx)
        IDX_MHASH0: begin
          state_next.mhash[0] = hwdata[MHASH_W-1:0];
        end
        IDX_MHASH1: begin
          state_next.mhash[1] = hwdata[MHASH_W-1:0];
        end
        IDX_MHASH2: begin
          state_next.mhash[2] = hwdata[MHASH_W-1:0];
        end
        IDX_MHASH3: begin
          state_next.mhash[3] = hwdata[MHASH_W-1:0];
        end
        IDX_ERX_CTRL: begin
          state_next.erx_en = hwdata[ERX_EN_BIT];
          state_next.erx_th = hwdata[ERX_TH_LSB +: ERX_TH_W];
        end
        IDX_RX_CTRL: begin
          state_next.rx_all    = hwdata[RXC_ALL_BIT];
          state_next.rx_all_mc = hwdata[RXC_MC_BIT];
        end
        IDX_INT_STS: begin
          int_clr = hwdata[INT_W-1:0];
        end
        IDX_INT_MASK: begin
          state_next.int_mask = hwdata[INT_W-1:0];
        end
        default: begin
          state_next.wr_idx = state_reg.wr_idx;
        end
      endcase
    end

    // Byte count and per-frame early flag
    state_next.byte_cnt = cnt_inc;
    if (rx_frame_start) begin
      state_next.early_flag = 1'b0;
    end
    // Fire only on a written byte: a stale count left from an earlier frame
    // must not raise the event when software enables between frames
    if (state_reg.erx_en && rx_byte_wr && over_th &&
        !(state_reg.early_flag && !rx_frame_start)) begin
      state_next.early_flag = 1'b1;
      int_set[INT_ERX_BIT]  = 1'b1;
    end

    // Multicast decision, pulsed once per presented address
    // Verdict holds between strobes so the buffer writer may sample it late
    // A drop also raises a status bit so software can count discards
    state_next.filt_valid = rx_da_valid;
    if (rx_da_valid) begin
      if (!da_is_mcast) begin
        state_next.filt_accept = 1'b1;
      end else if (state_reg.rx_all || state_reg.rx_all_mc) begin
        state_next.filt_accept = 1'b1;
      end else if (table_hit) begin
        state_next.filt_accept = 1'b1;
      end else begin
        state_next.filt_accept  = 1'b0;
        int_set[INT_DROP_BIT]   = 1'b1;
      end
    end

    // Sticky status: a new event beats a same-cycle clear
    // Losing an event to a racing clear would hide it from software
    state_next.int_sts = (state_reg.int_sts & ~int_clr) | int_set;
    state_next.irq     = |(state_next.int_sts & state_next.int_mask);

    // Address phase; read sees any write completing in this cycle
    state_next.wr_pend   = addr_phase && hwrite;
    state_next.wr_idx    = 6'h00;
    state_next.hreadyout = 1'b1;
    state_next.hresp     = HRESP_OKAY;
    // Writes outside the map are dropped here, before the data phase
    if (addr_phase && hwrite && !bus_idx[6]) begin
      state_next.wr_idx = bus_idx[5:0];
    end else if (addr_phase && hwrite) begin
      state_next.wr_pend = 1'b0;
    end
    if (addr_phase && !hwrite) begin
      state_next.hrdata = remf_read(state_next, bus_idx);
    end
  end

  // State register; reset values of every field
  // Reset branch holds constants only, field by field
  // Ready stays high in reset so the bus never sees a stall
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg.mhash       <= {MHASH_WORDS{MHASH_RST}};
      state_reg.erx_en      <= ERX_EN_RST;
      state_reg.erx_th      <= ERX_TH_RST;
      state_reg.rx_all      <= 1'b0;
      state_reg.rx_all_mc   <= 1'b0;
      state_reg.int_sts     <= INT_RST;
      state_reg.int_mask    <= INT_RST;
      state_reg.byte_cnt    <= '0;
      state_reg.early_flag  <= 1'b0;
      state_reg.wr_pend     <= 1'b0;
      state_reg.wr_idx      <= 6'h00;
      state_reg.hrdata      <= 32'h00000000;
      state_reg.hreadyout   <= 1'b1;
      state_reg.hresp       <= HRESP_OKAY;
      state_reg.filt_valid  <= 1'b0;
      state_reg.filt_accept <= 1'b0;
      state_reg.irq         <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  // No logic after the flops, so output timing is one clock to output
  assign hreadyout     = state_reg.hreadyout;
  assign hrdata        = state_reg.hrdata;
  assign hresp         = state_reg.hresp;
  assign filt_valid    = state_reg.filt_valid;
  assign filt_accept   = state_reg.filt_accept;
  assign early_rx_flag = state_reg.early_flag;
  assign irq           = state_reg.irq;

endmodule

// >>> shared/remf_pkg.sv
// Package of offsets, field layouts and constants for the early-receive and hash filter block
package remf_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [5:0] IDX_MHASH0   = 6'h00;
  localparam logic [5:0] IDX_MHASH1   = 6'h02;
  localparam logic [5:0] IDX_MHASH2   = 6'h04;
  localparam logic [5:0] IDX_MHASH3   = 6'h06;
  localparam logic [5:0] IDX_ERX_CTRL = 6'h0A;
  localparam logic [5:0] IDX_RX_CTRL  = 6'h0C;
  localparam logic [5:0] IDX_INT_STS  = 6'h0E;
  localparam logic [5:0] IDX_INT_MASK = 6'h10;

  // Early receive control fields
  localparam int         ERX_EN_BIT  = 7;
  localparam int         ERX_TH_LSB  = 0;
  localparam int         ERX_TH_W    = 5;
  localparam logic [4:0] ERX_TH_RST  = 5'h1F;
  localparam logic       ERX_EN_RST  = 1'h0;
  localparam int         ERX_UNIT_LG = 6;

  // Receive control fields
  localparam int RXC_ALL_BIT = 0;
  localparam int RXC_MC_BIT  = 1;

  // Interrupt status and mask fields
  localparam int         INT_W        = 2;
  localparam int         INT_ERX_BIT  = 0;
  localparam int         INT_DROP_BIT = 1;
  localparam logic [1:0] INT_RST      = 2'h0;

  // Hash table layout
  localparam int          MHASH_WORDS = 4;
  localparam int          MHASH_W     = 16;
  localparam logic [15:0] MHASH_RST   = 16'h0000;
  localparam int          HASH_IDX_W  = 6;

  // Destination address CRC
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam int          DA_W     = 48;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

endpackage

// >>> dv/remf_checker.sv
// Timing checker for the register bus, hash filter and early receive
`timescale 1ns/1ps
module remf_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        rx_frame_start,
  input wire logic        rx_byte_wr,
  input wire logic        rx_da_valid,
  input wire logic        filt_valid,
  input wire logic        filt_accept,
  input wire logic        early_rx_flag
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_rdy; hreadyout; endproperty
  a_rdy: assert property (p_rdy) else $error("ready dropped");
  property p_rd; !$past(hsel && htrans[1] && !hwrite) |-> $stable(hrdata); endproperty
  a_rd: assert property (p_rd) else $error("read data moved");
  property p_fv; rx_da_valid |=> filt_valid; endproperty
  a_fv: assert property (p_fv) else $error("no verdict");
  property p_fvc; filt_valid |-> $past(rx_da_valid); endproperty
  a_fvc: assert property (p_fvc) else $error("verdict without address");
  property p_acc; !filt_valid |-> $stable(filt_accept); endproperty
  a_acc: assert property (p_acc) else $error("verdict moved");
  // Flag lives for one frame only
  property p_clr; rx_frame_start |=> !early_rx_flag; endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_hold; early_rx_flag && !rx_frame_start |=> early_rx_flag; endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_rise; $rose(early_rx_flag) |-> $past(rx_byte_wr); endproperty
  a_rise: assert property (p_rise) else $error("flag without byte");
endmodule

bind remf_top remf_checker chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hreadyout, .hrdata,
  .rx_frame_start, .rx_byte_wr, .rx_da_valid, .filt_valid, .filt_accept, .early_rx_flag);

// >>> dv/remf_rx_model.sv
// Receive datapath model: frame bytes and address strobes
`timescale 1ns/1ps
module remf_rx_model (
  input  wire logic        hclk,
  output logic             rx_frame_start,
  output logic             rx_byte_wr,
  output logic             rx_da_valid,
  output logic [47:0]      rx_da
);
  initial begin
    rx_frame_start = 1'h0;
    rx_byte_wr = 1'h0;
    rx_da_valid = 1'h0;
    rx_da = 48'h0;
  end
  // One byte a cycle; start marks the first byte only
  task automatic send_bytes(input int n, input logic first);
    for (int i = 0; i < n; i++) begin
      @(posedge hclk);
      rx_frame_start <= first && (i == 0);
      rx_byte_wr <= 1'h1;
    end
    @(posedge hclk);
    rx_frame_start <= 1'h0;
    rx_byte_wr <= 1'h0;
    @(posedge hclk);
  endtask
  // Bus shows the inverse once released, so stale values never match
  task automatic send_da(input logic [47:0] d);
    @(posedge hclk);
    rx_da_valid <= 1'h1;
    rx_da <= d;
    @(posedge hclk);
    rx_da_valid <= 1'h0;
    rx_da <= ~d;
    repeat (2) @(posedge hclk);
  endtask
endmodule

// >>> dv/tb_top.sv
// Bench for register access, hash filter and early receive
`timescale 1ns/1ps
module tb_top;
  import remf_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        rx_frame_start;
  logic        rx_byte_wr;
  logic        rx_da_valid;
  logic [47:0] rx_da;
  logic        filt_valid;
  logic        filt_accept;
  logic        early_rx_flag;
  logic        irq;
  int          mismatches;
  int          compares;
  logic [31:0] rd;
  logic [47:0] das [3] = '{48'h0000FB005E01, 48'h123456789ABD, 48'hFFFFFFFFFFFF};

  remf_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .rx_frame_start, .rx_byte_wr,
    .rx_da_valid, .rx_da, .filt_valid, .filt_accept, .early_rx_flag, .irq);
  remf_rx_model rxm (.hclk, .rx_frame_start, .rx_byte_wr, .rx_da_valid, .rx_da);

  initial begin
    hclk = 1'h0;
    forever #4 hclk = ~hclk;
  end

  task automatic give_verdict();
    if (mismatches == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bounded wait for ready; a hung bus ends the run
  task automatic edge_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 100);
    if (n >= 100) begin
      mismatches++;
      give_verdict();
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    edge_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy();
    rd = hrdata;
  endtask
  task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk("resp", 32'(HRESP_OKAY), 32'(hresp));
    chk(nm, e, rd);
  endtask
  function automatic logic [31:0] ba(input logic [5:0] i);
    return {24'h0, i, 2'h0};
  endfunction
  // Serial CRC over the address, first octet's low bit first
  function automatic logic [5:0] hidx(input logic [47:0] d);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < DA_W; i++)
      c = c[31] ^ d[i] ? {c[30:0], 1'h0} ^ CRC_POLY : {c[30:0], 1'h0};
    return c[31:26];
  endfunction
  // Only the selected bit set, or all bits but it
  task automatic set_tab(input logic [5:0] x, input logic inv);
    logic [15:0] v;
    for (int w = 0; w < 4; w++) begin
      v = (w == x[5:4]) ? 16'h0001 << x[3:0] : 16'h0000;
      bus(1'h1, ba(6'(w * 2)), {16'h0, inv ? ~v : v});
    end
  endtask

  initial begin
    hresetn = 1'h0;
    hsel = 1'h1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    mismatches = 0;
    compares = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    for (int w = 0; w < 4; w++) begin
      rchk("hash reset", ba(6'(w * 2)), 32'h0);
      bus(1'h1, ba(6'(w * 2)), 32'hFFFF5A00 | 32'(w));
      rchk("hash rw", ba(6'(w * 2)), 32'h5A00 | 32'(w));
    end
    rchk("erx reset", ba(IDX_ERX_CTRL), 32'h1F);
    bus(1'h1, ba(IDX_INT_MASK), 32'h3);
    bus(1'h1, ba(IDX_ERX_CTRL), 32'h01);
    rxm.send_bytes(70, 1'h1);
    chk("flag disabled", 32'h0, early_rx_flag);
    rchk("status disabled", ba(IDX_INT_STS), 32'h0);
    bus(1'h1, ba(IDX_ERX_CTRL), 32'h81);
    rxm.send_bytes(64, 1'h1);
    chk("flag at 64", 32'h0, early_rx_flag);
    rxm.send_bytes(1, 1'h0);
    chk("flag at 65", 32'h1, early_rx_flag);
    rchk("status set", ba(IDX_INT_STS), 32'h1);
    chk("irq on", 32'h1, irq);
    bus(1'h1, ba(IDX_INT_MASK), 32'h0);
    repeat (2) @(posedge hclk);
    chk("irq masked", 32'h0, irq);
    rxm.send_bytes(1, 1'h1);
    chk("flag new frame", 32'h0, early_rx_flag);
    bus(1'h1, ba(IDX_INT_STS), 32'h3);
    rchk("status clear", ba(IDX_INT_STS), 32'h0);
    // Each address passes with only its bit, fails with all others
    foreach (das[k]) begin
      set_tab(hidx(das[k]), 1'h0);
      rxm.send_da(das[k]);
      chk("accept", 32'h1, filt_accept);
      set_tab(hidx(das[k]), 1'h1);
      rxm.send_da(das[k]);
      chk("drop", 32'h0, filt_accept);
    end
    rchk("drop status", ba(IDX_INT_STS), 32'h2);
    set_tab(hidx(das[0]), 1'h1);
    for (int m = 0; m < 3; m++) begin
      bus(1'h1, ba(IDX_RX_CTRL), 32'(m));
      rxm.send_da(das[0]);
      chk("override", 32'(m != 0), filt_accept);
    end
    give_verdict();
  end
endmodule
